// >>> logic/lsef_defines.svh
`ifndef LSEF_DEFINES_SVH
`define LSEF_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define LSEF_OFS_CTRL 6'h00
`define LSEF_OFS_OPEN_LO 6'h04
`define LSEF_OFS_OPEN_HI 6'h08
`define LSEF_OFS_CLOSED_LO 6'h0C
`define LSEF_OFS_CLOSED_HI 6'h10
`define LSEF_OFS_INTERVAL 6'h14
`define LSEF_OFS_LATENCY 6'h18
`define LSEF_OFS_TIMEOUT 6'h1C
`define LSEF_OFS_LINK_EVT 6'h20
`define LSEF_OFS_STATUS 6'h24
`define LSEF_OFS_MASK 6'h28
`define LSEF_OFS_CREDIT 6'h2C

// Field positions.
`define LSEF_CTRL_DISC_DONE 0
`define LSEF_CTRL_DISC_NONE 1
`define LSEF_EVT_CONNECT 0
`define LSEF_EVT_UPDATE 1
`define LSEF_ST_PIPE 0
`define LSEF_ST_TIMING 1
`define LSEF_ST_CREDIT 2

// Frame headers: the length byte counts the code byte and the content.
`define LSEF_PIPE_LEN 8'h11
`define LSEF_PIPE_CODE 8'h88
`define LSEF_TIMING_LEN 8'h07
`define LSEF_TIMING_CODE 8'h89
`define LSEF_CREDIT_LEN 8'h02
`define LSEF_CREDIT_CODE 8'h8A
`define LSEF_LATENCY_MAX 16'h03E8
`define LSEF_CREDIT_MAX 8'hFF

// Reset values.
`define LSEF_RST_WORD 32'h0000_0000
`define LSEF_RST_MASK 3'h0

`endif

// >>> logic/lsef_pkg.sv
package lsef_pkg;

   typedef enum logic [1:0] {LSEF_PIPE, LSEF_TIMING, LSEF_CREDIT} lsef_kind_t;

   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } lsef_av_req_t;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } lsef_av_rsp_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lsef_tx_t;

   typedef struct packed {
      logic [1:0] ctrl;
      logic [63:0] open_map;
      logic [63:0] closed_map;
      logic [15:0] interval;
      logic [15:0] latency;
      logic [15:0] timeout;
      logic [2:0] mask;
      logic [7:0] credit;
      logic pipe_pend;
      logic timing_pend;
      logic busy;
      lsef_kind_t kind;
      logic [4:0] idx;
      logic [4:0] total;
      logic [17:0][7:0] frame;
      lsef_tx_t tx;
      lsef_av_rsp_t rsp;
      logic irq;
   } lsef_state_t;

   typedef struct packed {
      logic [2:0] flags;
   } lsef_flag_state_t;

endpackage

// >>> logic/lsef_flags.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky flags: hardware sets, software clears by writing one; a set in the
// clearing cycle wins so that no event is lost.
module lsef_flags
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] set,
   input wire logic [2:0] clr,
   output logic [2:0] q
);

   lsef_pkg::lsef_flag_state_t s_r;
   lsef_pkg::lsef_flag_state_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.flags = (s_r.flags & ~clr) | set;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r.flags <= 3'h0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.flags;

endmodule

`default_nettype wire

// >>> logic/lsef_framer.sv
// Operation
// - Pipe report: length 17, code 88h, two bitmaps.
// - Open bitmap bit set when pipe open; 63 unused.
// - Open bit 0 reports discovery completed.
// - Discovery not needed reports bit 0 as one.
// - Closed bitmap bits 1-62 flag pipes needing opening.
// - Closed bitmap bit 0 always sent zero.
// - Timing report: length 7, code 89h, three fields.
// - Timing report on connect and parameter update.
// - Interval sent most significant byte first.
// - Skip count low byte first, at most 3E8h.
// - Link loss timeout in 10 ms units.
// - Credit message: length 2, code 8Ah, count.
// - Credit count equals completed data command slots.
// - Event messages flow only toward the host.
// - Bitmaps numbered from first byte, LSB upward.
// - New pipe report on every availability change.
`timescale 1ns/1ps
`default_nettype none
`include "lsef_defines.svh"

module lsef_framer
(
   input wire logic clk,
   input wire logic rst_n,
   input wire lsef_pkg::lsef_av_req_t av_req,
   output lsef_pkg::lsef_av_rsp_t av_rsp,
   input wire logic data_cmd_done,
   output lsef_pkg::lsef_tx_t tx_out,
   input wire logic tx_ready,
   output logic irq
);

   lsef_pkg::lsef_state_t s_r;
   lsef_pkg::lsef_state_t s_nxt;
   logic [2:0] status;
   logic [2:0] frame_done;
   logic [2:0] status_clr;
   logic [63:0] eff_open;
   logic [63:0] eff_closed;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [63:0] open_view(input logic [63:0] m, input logic [1:0] c);
      // Bit 0 is discovery status; bit 63 carries no pipe.
      open_view = {1'b0, m[62:1], c[`LSEF_CTRL_DISC_DONE] | c[`LSEF_CTRL_DISC_NONE]};
   endfunction

   function automatic logic [63:0] closed_view(input logic [63:0] m);
      closed_view = {1'b0, m[62:1], 1'b0};
   endfunction

   assign eff_open = open_view(s_r.open_map, s_r.ctrl);
   assign eff_closed = closed_view(s_r.closed_map);

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      logic acc;
      logic wr_now;
      logic inc;
      logic [31:0] rd;
      logic [15:0] lat;
      acc = av_req.read | av_req.write;
      wr_now = av_req.write & ~s_r.rsp.waitrequest;
      inc = data_cmd_done & (s_r.credit != `LSEF_CREDIT_MAX);
      rd = `LSEF_RST_WORD;
      lat = (s_r.latency > `LSEF_LATENCY_MAX) ? `LSEF_LATENCY_MAX : s_r.latency;
      s_nxt = s_r;
      frame_done = 3'h0;
      status_clr = 3'h0;

      unique case (av_req.address)
         `LSEF_OFS_CTRL: rd = {30'h0, s_r.ctrl};
         `LSEF_OFS_OPEN_LO: rd = s_r.open_map[31:0];
         `LSEF_OFS_OPEN_HI: rd = s_r.open_map[63:32];
         `LSEF_OFS_CLOSED_LO: rd = s_r.closed_map[31:0];
         `LSEF_OFS_CLOSED_HI: rd = s_r.closed_map[63:32];
         `LSEF_OFS_INTERVAL: rd = {16'h0, s_r.interval};
         `LSEF_OFS_LATENCY: rd = {16'h0, s_r.latency};
         `LSEF_OFS_TIMEOUT: rd = {16'h0, s_r.timeout};
         `LSEF_OFS_LINK_EVT: rd = {30'h0, s_r.timing_pend, s_r.pipe_pend};
         `LSEF_OFS_STATUS: rd = {29'h0, status};
         `LSEF_OFS_MASK: rd = {29'h0, s_r.mask};
         `LSEF_OFS_CREDIT: rd = {24'h0, s_r.credit};
         default: rd = `LSEF_RST_WORD;
      endcase

      // One wait cycle per access; the request is taken while waitrequest is low.
      s_nxt.rsp.waitrequest = 1'b1;
      if (acc && s_r.rsp.waitrequest)
      begin
         s_nxt.rsp.waitrequest = 1'b0;
         s_nxt.rsp.readdata = av_req.read ? rd : `LSEF_RST_WORD;
      end

      // Frame start; a pipe report outranks timing, timing outranks credit.
      if (!s_r.busy)
      begin
         s_nxt.idx = 5'h0;
         s_nxt.frame = '0;
         if (s_r.pipe_pend)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.pipe_pend = 1'b0;
            s_nxt.kind = lsef_pkg::LSEF_PIPE;
            s_nxt.total = 5'd18;
            s_nxt.frame[0] = `LSEF_PIPE_LEN;
            s_nxt.frame[1] = `LSEF_PIPE_CODE;
            for (int i = 0; i < 8; i++)
            begin
               s_nxt.frame[2 + i] = eff_open[8 * i +: 8];
               s_nxt.frame[10 + i] = eff_closed[8 * i +: 8];
            end
         end
         else if (s_r.timing_pend)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.timing_pend = 1'b0;
            s_nxt.kind = lsef_pkg::LSEF_TIMING;
            s_nxt.total = 5'd8;
            s_nxt.frame[0] = `LSEF_TIMING_LEN;
            s_nxt.frame[1] = `LSEF_TIMING_CODE;
            s_nxt.frame[2] = s_r.interval[15:8];
            s_nxt.frame[3] = s_r.interval[7:0];
            s_nxt.frame[4] = lat[7:0];
            s_nxt.frame[5] = lat[15:8];
            s_nxt.frame[6] = s_r.timeout[7:0];
            s_nxt.frame[7] = s_r.timeout[15:8];
         end
         else if (s_r.credit != 8'h00)
         begin
            s_nxt.busy = 1'b1;
            s_nxt.kind = lsef_pkg::LSEF_CREDIT;
            s_nxt.total = 5'd3;
            s_nxt.frame[0] = `LSEF_CREDIT_LEN;
            s_nxt.frame[1] = `LSEF_CREDIT_CODE;
            s_nxt.frame[2] = s_r.credit;
         end
      end

      // Credits: the whole count goes out, so only this cycle's release remains.
      if (!s_r.busy && !s_r.pipe_pend && !s_r.timing_pend && s_r.credit != 8'h00)
      begin
         s_nxt.credit = {7'h0, inc};
      end
      else
      begin
         s_nxt.credit = s_r.credit + {7'h0, inc};
      end

      // Byte stream toward the host only; a byte stands until tx_ready.
      if (s_r.busy && (!s_r.tx.valid || tx_ready))
      begin
         if (s_r.idx < s_r.total)
         begin
            s_nxt.tx.valid = 1'b1;
            s_nxt.tx.data = s_r.frame[s_r.idx];
            s_nxt.idx = s_r.idx + 5'h1;
         end
         else
         begin
            s_nxt.tx.valid = 1'b0;
            s_nxt.busy = 1'b0;
            frame_done[s_r.kind] = 1'b1;
         end
      end

      if (wr_now)
      begin
         unique case (av_req.address)
            `LSEF_OFS_CTRL: s_nxt.ctrl = av_req.writedata[1:0];
            `LSEF_OFS_OPEN_LO: s_nxt.open_map[31:0] = av_req.writedata;
            `LSEF_OFS_OPEN_HI: s_nxt.open_map[63:32] = av_req.writedata;
            `LSEF_OFS_CLOSED_LO: s_nxt.closed_map[31:0] = av_req.writedata;
            `LSEF_OFS_CLOSED_HI: s_nxt.closed_map[63:32] = av_req.writedata;
            `LSEF_OFS_INTERVAL: s_nxt.interval = av_req.writedata[15:0];
            `LSEF_OFS_LATENCY: s_nxt.latency = av_req.writedata[15:0];
            `LSEF_OFS_TIMEOUT: s_nxt.timeout = av_req.writedata[15:0];
            `LSEF_OFS_LINK_EVT:
            begin
               if (av_req.writedata[`LSEF_EVT_CONNECT] || av_req.writedata[`LSEF_EVT_UPDATE])
               begin
                  s_nxt.timing_pend = 1'b1;
               end
            end
            `LSEF_OFS_STATUS: status_clr = av_req.writedata[2:0];
            `LSEF_OFS_MASK: s_nxt.mask = av_req.writedata[2:0];
            default: s_nxt.ctrl = s_r.ctrl;
         endcase
      end

      // Any change the host would see in either bitmap queues a new report.
      if (open_view(s_nxt.open_map, s_nxt.ctrl) != eff_open || closed_view(s_nxt.closed_map) != eff_closed)
      begin
         s_nxt.pipe_pend = 1'b1;
      end

      // Follows status by one cycle, so a cleared flag drops irq one edge later.
      s_nxt.irq = |(status & s_r.mask);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.rsp.waitrequest <= 1'b1;
         s_r.mask <= `LSEF_RST_MASK;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   lsef_flags u_flags
   (
      .clk(clk),
      .rst_n(rst_n),
      .set(frame_done),
      .clr(status_clr),
      .q(status)
   );

   assign av_rsp = s_r.rsp;
   assign tx_out = s_r.tx;
   assign irq = s_r.irq;

   ////////////////////////////////////////////////////////////////////////////

   pipe_header_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy && s_r.kind == lsef_pkg::LSEF_PIPE |-> s_r.frame[0] == 8'h11 && s_r.frame[1] == 8'h88)
      else $error("pipe report header wrong");

   open_top_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy && s_r.kind == lsef_pkg::LSEF_PIPE |-> s_r.frame[9][7] == 1'b0)
      else $error("open bitmap bit 63 set");

   discovery_bit_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_PIPE
      |-> s_r.frame[2][0] == ($past(s_r.ctrl[0]) | $past(s_r.ctrl[1])))
      else $error("discovery status bit wrong");

   closed_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy && s_r.kind == lsef_pkg::LSEF_PIPE |-> s_r.frame[10][0] == 1'b0 && s_r.frame[17][7] == 1'b0)
      else $error("closed bitmap reserved bit set");

   timing_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy && s_r.kind == lsef_pkg::LSEF_TIMING |-> s_r.frame[0] == 8'h07 && s_r.frame[1] == 8'h89
      && {s_r.frame[5], s_r.frame[4]} <= 16'h03E8)
      else $error("timing report header or skip count wrong");

   interval_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_TIMING
      |-> {s_r.frame[2], s_r.frame[3]} == $past(s_r.interval))
      else $error("interval byte order wrong");

   credit_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_CREDIT
      |-> s_r.frame[2] == $past(s_r.credit) && s_r.frame[0] == 8'h02 && s_r.credit <= 8'h01)
      else $error("credit message wrong");

   tx_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.tx.valid && !tx_ready |=> s_r.tx.valid && $stable(s_r.tx.data))
      else $error("byte dropped before accept");

   frame_length_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy |-> {3'h0, s_r.total} == s_r.frame[0] + 8'h01)
      else $error("length byte mismatch");

   pipe_change_a: assert property (@(posedge clk) disable iff (!rst_n)
      !$stable(eff_open) || !$stable(eff_closed) |-> s_r.pipe_pend)
      else $error("pipe change not queued");

   credit_code_a: assert property (@(posedge clk) disable iff (!rst_n)
      s_r.busy && s_r.kind == lsef_pkg::LSEF_CREDIT |-> s_r.frame[1] == 8'h8A && s_r.total == 5'd3)
      else $error("credit message code wrong");

   timing_queue_a: assert property (@(posedge clk) disable iff (!rst_n)
      av_req.write && !s_r.rsp.waitrequest && av_req.address == `LSEF_OFS_LINK_EVT && av_req.writedata[1:0] != 2'h0
      |=> s_r.timing_pend)
      else $error("timing report not queued");

   timeout_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_TIMING
      |-> {s_r.frame[7], s_r.frame[6]} == $past(s_r.timeout))
      else $error("link loss timeout bytes wrong");

   open_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_PIPE
      |-> s_r.frame[2][7:1] == $past(s_r.open_map[7:1]) && s_r.frame[10][7:1] == $past(s_r.closed_map[7:1]))
      else $error("bitmap byte order wrong");

   closed_pipes_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(s_r.busy) && s_r.kind == lsef_pkg::LSEF_PIPE
      |-> {s_r.frame[17][6:0], s_r.frame[16]} == $past(s_r.closed_map[62:48]))
      else $error("closed bitmap upper pipes wrong");

endmodule

`default_nettype wire

// >>> dv/lsef_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Receive-only host end. It never drives a byte back and never acts on a pipe number.
// Acceptance is withheld at random, so the framer meets both prompt and slow hosts.
module lsef_host_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire lsef_pkg::lsef_tx_t tx_in,
   input wire logic stall,
   output logic tx_ready
);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_ready <= 1'b0;
      else
         tx_ready <= !stall && (!tx_in.valid || ($urandom_range(3) != 0));
   end
endmodule

`default_nettype wire

// >>> dv/link_status_event_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module link_status_event_framer_tb;
   logic clk = 1'b0;
   logic rst_n;
   logic done;
   logic stall;
   logic ready;
   logic irq;
   lsef_pkg::lsef_av_req_t req;
   lsef_pkg::lsef_av_rsp_t rsp;
   lsef_pkg::lsef_tx_t tx;
   logic [31:0] bq[$];
   logic [31:0] rq[$];
   logic [63:0] om = '0;
   logic [63:0] cm = '0;
   logic [1:0] ctl = '0;
   int n_fail = 0;
   int comparisons = 0;

   always #50 clk = ~clk;

   lsef_framer lsef_framer_inst (.clk(clk), .rst_n(rst_n), .av_req(req), .av_rsp(rsp),
      .data_cmd_done(done), .tx_out(tx), .tx_ready(ready), .irq(irq));
   lsef_host_model lsef_host_model_inst (.clk(clk), .rst_n(rst_n), .tx_in(tx), .stall(stall),
      .tx_ready(ready));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic void chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endfunction

   task automatic end_sim();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask

   // An unexpected byte meets an empty queue and is reported against an impossible value.
   always @(posedge clk)
   begin
      if (rst_n && tx.valid && ready)
         chk({24'h0, tx.data}, bq.size() != 0 ? bq.pop_front() : 32'hFFFF_FFFF);
      if (rst_n && req.read && !rsp.waitrequest)
         chk(rsp.readdata, rq.size() != 0 ? rq.pop_front() : 32'hFFFF_FFFF);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      req <= '{a, !w, w, d};
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (rsp.waitrequest !== 1'b0 && k < 20);
      req <= '0;
      if (rsp.waitrequest !== 1'b0)
      begin
         n_fail++;
         end_sim();
      end
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic settle();
      int k;
      k = 0;
      while (bq.size() != 0 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      if (bq.size() != 0)
      begin
         n_fail++;
         end_sim();
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic wr_pipe(input logic [5:0] a, input logic [31:0] d);
      logic [127:0] m;
      logic [127:0] p;
      p = {1'b0, cm[62:1], 1'b0, 1'b0, om[62:1], ctl[0] | ctl[1]};
      case (a)
         6'h04: om[31:0] = d;
         6'h08: om[63:32] = d;
         6'h0C: cm[31:0] = d;
         6'h10: cm[63:32] = d;
         default: ctl = d[1:0];
      endcase
      bus(1'b1, a, d);
      m = {1'b0, cm[62:1], 1'b0, 1'b0, om[62:1], ctl[0] | ctl[1]};
      // Only a change of what the host would see earns a new report.
      if (m != p)
      begin
         bq.push_back(32'h11);
         bq.push_back(32'h88);
         for (int k = 0; k < 16; k++)
            bq.push_back({24'h0, m[8*k +: 8]});
      end
   endtask

   task automatic timing(input logic [1:0] e, input logic [15:0] l);
      logic [15:0] iv;
      logic [15:0] tv;
      logic [15:0] c;
      iv = 16'($urandom());
      tv = 16'($urandom());
      c = (l > 16'h03E8) ? 16'h03E8 : l;
      bus(1'b1, 6'h14, {16'hA5A5, iv});
      rd(6'h14, {16'h0, iv});
      bus(1'b1, 6'h18, {16'h0, l});
      bus(1'b1, 6'h1C, {16'h0, tv});
      bus(1'b1, 6'h20, {30'h0, e});
      bq.push_back(32'h07);
      bq.push_back(32'h89);
      bq.push_back({24'h0, iv[15:8]});
      bq.push_back({24'h0, iv[7:0]});
      bq.push_back({24'h0, c[7:0]});
      bq.push_back({24'h0, c[15:8]});
      bq.push_back({24'h0, tv[7:0]});
      bq.push_back({24'h0, tv[15:8]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(41));
      rst_n <= 1'b0;
      done <= 1'b0;
      stall <= 1'b1;
      req <= '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      stall <= 1'b0;
      for (int a = 0; a <= 48; a += 4)
         rd(a[5:0], 32'h0);
      // Writes to an unmapped and a read-only offset must change nothing.
      bus(1'b1, 6'h30, 32'hFFFF_FFFF);
      bus(1'b1, 6'h2C, 32'hFFFF_FFFF);
      rd(6'h30, 32'h0);
      rd(6'h2C, 32'h0);
      tdone("reset");
      for (int i = 0; i < 7; i++)
      begin
         wr_pipe(i < 4 ? 6'(4 + 4 * i) : 6'h00, i < 4 ? $urandom() : i == 4 ? 32'h2 : i == 5 ? 32'h0 : 32'h1);
         settle();
      end
      // Rewriting an unchanged value must not produce a report.
      bus(1'b1, 6'h04, om[31:0]);
      settle();
      tdone("pipe");
      timing(2'h1, 16'h03E8);
      settle();
      timing(2'h2, 16'($urandom()));
      settle();
      timing(2'h3, 16'hFFFF);
      settle();
      tdone("timing");
      // The host stalls so that credits pile up behind two queued reports.
      stall <= 1'b1;
      wr_pipe(6'h04, $urandom());
      repeat (6) @(posedge clk);
      repeat (5)
      begin
         @(posedge clk);
         done <= 1'b1;
      end
      @(posedge clk);
      done <= 1'b0;
      timing(2'h2, 16'h0005);
      rd(6'h2C, 32'h5);
      bq.push_back(32'h02);
      bq.push_back(32'h8A);
      bq.push_back(32'h05);
      stall <= 1'b0;
      settle();
      rd(6'h2C, 32'h0);
      tdone("queue");
      rd(6'h24, 32'h7);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 6'h28, 32'h5);
      rd(6'h28, 32'h5);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 6'h24, 32'h5);
      rd(6'h24, 32'h2);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 6'h28, 32'h7);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, 6'h24, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      tdone("irq");
      if (bq.size() != 0 || rq.size() != 0)
         n_fail++;
      end_sim();
   end
endmodule

`default_nettype wire
